/* File: core/iuv_fault.sv */
// Input undervoltage fault detection, status latching and retry control
//
// Notes on behaviour
// - Fault threshold held as Linear-11 word.
// - Threshold resets to CB40h, 6.5 V.
// - Writes outside 0..16 V are rejected.
// - Fault sets word, input and fault status bits.
// - Action byte resets to 80h.
// - Mode 10 disables then retries; others unused.
// - Fault pulls alert low, sets status bit.
// - Status latched until clear-faults command.
// - Retry field 000 keeps output off.
// - Nonzero retry field restarts until switched off.
// - Restart waits for input above warning threshold.
// - Restart spacing is (delay+1) times 35 ms.
module iuv_fault #(
  parameter int RETRY_UNIT = iuv_pkg::RETRY_UNIT_CYC  // Cycles per 35 ms step
) (
  input  wire logic        clk_sys,          // System clock, 10 MHz
  input  wire logic        resetn,           // Async reset, active low
  input  wire logic        cmd_wr,           // Command write strobe
  input  wire logic [7:0]  cmd_code,         // Command code
  input  wire logic [15:0] cmd_data,         // Write data
  input  wire logic [7:0]  rd_code,          // Read command code
  output logic      [15:0] rd_data,          // Read data
  input  wire logic        meas_valid,       // New input measurement
  input  wire logic [15:0] meas_vin,         // Measured input, Linear-11
  input  wire logic [15:0] warn_threshold,   // Input low warning threshold, Linear-11
  input  wire logic        output_enable_in, // Enable pin or operation command on
  output logic             output_on,        // Power stage permitted
  output logic             host_alert_line_n,// Alert to host, active low
  output logic      [15:0] status_word,      // Status word bits owned here
  output logic      [7:0]  status_input      // Status input bits owned here
);
  // ---------------------------------------------------------------
  // Conversions
  // ---------------------------------------------------------------
  logic        [15:0] thr_reg, thr_next;
  logic        [7:0]  act_reg, act_next;
  logic signed [31:0] thr_mv, wr_mv, meas_mv, warn_mv;

  iuv_lin11 u_thr  (.code(thr_reg),        .mv(thr_mv));
  iuv_lin11 u_wr   (.code(cmd_data),       .mv(wr_mv));
  iuv_lin11 u_meas (.code(meas_vin),       .mv(meas_mv));
  iuv_lin11 u_warn (.code(warn_threshold), .mv(warn_mv));

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic wr_thr_ok;
  logic clear_cmd;

  always_comb begin
    wr_thr_ok = (wr_mv >= 0) && (wr_mv <= iuv_pkg::MV_MAX);
    clear_cmd = cmd_wr && (cmd_code == iuv_pkg::CMD_CLEAR_FAULTS);
    thr_next  = thr_reg;
    act_next  = act_reg;
    if (cmd_wr && cmd_code == iuv_pkg::CMD_FAULT_THRESHOLD && wr_thr_ok) begin
      thr_next = cmd_data;
    end
    if (cmd_wr && cmd_code == iuv_pkg::CMD_FAULT_ACTION) begin
      act_next = cmd_data[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      thr_reg <= iuv_pkg::THRESHOLD_RESET;
      act_reg <= iuv_pkg::ACTION_RESET;
    end else begin
      thr_reg <= thr_next;
      act_reg <= act_next;
    end
  end

  always_comb begin
    case (rd_code)
      iuv_pkg::CMD_FAULT_THRESHOLD: rd_data = thr_reg;
      iuv_pkg::CMD_FAULT_ACTION:    rd_data = {8'h00, act_reg};
      default:                      rd_data = 16'h0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Detection and status
  // ---------------------------------------------------------------
  logic uv_event;
  logic fault_reg, fault_next;
  logic above_warn_reg, above_warn_next;

  always_comb begin
    uv_event        = meas_valid && (meas_mv < thr_mv);
    above_warn_next = above_warn_reg;
    if (meas_valid) begin
      above_warn_next = meas_mv > warn_mv;
    end
    fault_next = fault_reg;
    if (clear_cmd) begin
      fault_next = 1'b0;
    end
    if (uv_event) begin
      fault_next = 1'b1;  // Set beats clear
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fault_reg      <= 1'b0;
      above_warn_reg <= 1'b0;
    end else begin
      fault_reg      <= fault_next;
      above_warn_reg <= above_warn_next;
    end
  end

  always_comb begin
    status_word                        = 16'h0000;
    status_input                       = 8'h00;
    status_word[iuv_pkg::SW_NONE_ABOVE] = fault_reg;
    status_word[iuv_pkg::SW_INPUT]      = fault_reg;
    status_input[iuv_pkg::SI_UV_FAULT]  = fault_reg;
    host_alert_line_n                   = ~fault_reg;
  end

  property p_fault_sets;
    @(posedge clk_sys) disable iff (!resetn)
      uv_event |=> fault_reg && !host_alert_line_n && status_word[iuv_pkg::SW_INPUT]
        && status_word[iuv_pkg::SW_NONE_ABOVE] && status_input[iuv_pkg::SI_UV_FAULT];
  endproperty
  a_fault_sets: assert property (p_fault_sets) else $error("fault did not set status");

  property p_fault_held;
    @(posedge clk_sys) disable iff (!resetn)
      fault_reg && !clear_cmd |=> fault_reg;
  endproperty
  a_fault_held: assert property (p_fault_held) else $error("fault bit dropped");

  property p_fault_clear;
    @(posedge clk_sys) disable iff (!resetn)
      clear_cmd && !uv_event |=> !fault_reg && host_alert_line_n;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("clear did not clear");

  property p_thr_reject;
    @(posedge clk_sys) disable iff (!resetn)
      cmd_wr && (cmd_code == iuv_pkg::CMD_FAULT_THRESHOLD) && !wr_thr_ok |=> $stable(thr_reg);
  endproperty
  a_thr_reject: assert property (p_thr_reject) else $error("bad threshold stored");

  // ---------------------------------------------------------------
  // Enable pin synchroniser
  // ---------------------------------------------------------------
  logic en_meta_reg, en_sync_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      en_meta_reg <= 1'b0;
      en_sync_reg <= 1'b0;
    end else begin
      en_meta_reg <= output_enable_in;
      en_sync_reg <= en_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // Response state machine
  // ---------------------------------------------------------------
  localparam int DELAY_STEPS = 1 << (iuv_pkg::DELAY_HI - iuv_pkg::DELAY_LO + 1);
  localparam int CNT_W       = $clog2(DELAY_STEPS * RETRY_UNIT + 1);

  // Loaded one short so the start lands exactly on the spacing
  function automatic logic [CNT_W-1:0] retry_cycles(input logic [2:0] dly);
    return CNT_W'((int'(dly) + 1) * RETRY_UNIT - 1);
  endfunction

  iuv_pkg::iuv_state_t state_reg, state_next;
  logic [CNT_W-1:0]    cnt_reg, cnt_next;
  logic                on_reg, on_next;
  logic                retry_on;

  // Timer runs from fault detection; input recovery only gates the start
  always_comb begin
    retry_on   = (act_reg[iuv_pkg::MODE_HI:iuv_pkg::MODE_LO] == iuv_pkg::MODE_RETRY)
                 && (act_reg[iuv_pkg::RETRY_HI:iuv_pkg::RETRY_LO] != 3'h0);
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
    if (uv_event) begin
      cnt_next = retry_cycles(act_reg[iuv_pkg::DELAY_HI:iuv_pkg::DELAY_LO]);
    end
    case (state_reg)
      iuv_pkg::IUV_RUN: begin
        if (uv_event) begin
          state_next = iuv_pkg::IUV_OFF;
        end
      end
      iuv_pkg::IUV_OFF: begin
        if (retry_on && en_sync_reg) begin
          state_next = iuv_pkg::IUV_WAIT;
        end else if (clear_cmd && !uv_event) begin
          state_next = iuv_pkg::IUV_RUN;
        end
      end
      iuv_pkg::IUV_WAIT: begin
        if (!en_sync_reg || !retry_on) begin
          state_next = iuv_pkg::IUV_OFF;
        end else if ((cnt_reg == '0) && above_warn_reg && !uv_event) begin
          state_next = iuv_pkg::IUV_RESTART;
        end
      end
      iuv_pkg::IUV_RESTART: begin
        if (uv_event) begin
          state_next = iuv_pkg::IUV_OFF;
        end else begin
          state_next = iuv_pkg::IUV_RUN;
        end
      end
      default: begin
        state_next = iuv_pkg::IUV_OFF;
      end
    endcase
    on_next = ((state_next == iuv_pkg::IUV_RUN) || (state_next == iuv_pkg::IUV_RESTART)) && en_sync_reg;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= iuv_pkg::IUV_RUN;
      cnt_reg   <= '0;
      on_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      on_reg    <= on_next;
    end
  end

  assign output_on = on_reg;

  sequence s_wait_done;
    (state_reg == iuv_pkg::IUV_WAIT) && (cnt_reg == '0) && above_warn_reg && en_sync_reg && retry_on && !uv_event;
  endsequence

  sequence s_restart_on;
    (state_reg == iuv_pkg::IUV_RESTART) && output_on;
  endsequence

  property p_retry_step;
    @(posedge clk_sys) disable iff (!resetn)
      s_wait_done |=> s_restart_on;
  endproperty
  a_retry_step: assert property (p_retry_step) else $error("restart not taken");

  property p_restart_gate;
    @(posedge clk_sys) disable iff (!resetn)
      (state_reg == iuv_pkg::IUV_RESTART) |-> $past(above_warn_reg) && ($past(cnt_reg) == '0);
  endproperty
  a_restart_gate: assert property (p_restart_gate) else $error("early restart");

  property p_off_on_fault;
    @(posedge clk_sys) disable iff (!resetn)
      uv_event |=> !output_on;
  endproperty
  a_off_on_fault: assert property (p_off_on_fault) else $error("output on after fault");

  property p_no_retry;
    @(posedge clk_sys) disable iff (!resetn)
      (state_reg == iuv_pkg::IUV_OFF) && !retry_on && !clear_cmd |=> !output_on && (state_reg == iuv_pkg::IUV_OFF);
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("left off without clear");

  property p_mode_unused;
    @(posedge clk_sys) disable iff (!resetn)
      (state_reg == iuv_pkg::IUV_OFF) && (act_reg[iuv_pkg::MODE_HI:iuv_pkg::MODE_LO] != iuv_pkg::MODE_RETRY)
        |=> (state_reg != iuv_pkg::IUV_WAIT);
  endproperty
  a_mode_unused: assert property (p_mode_unused) else $error("retry in unused mode");
endmodule

/* File: core/iuv_pkg.sv */
// Package: command codes, field layouts, reset values and timing for the input undervoltage handler
package iuv_pkg;
  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_FAULT_THRESHOLD = 8'h59;
  localparam logic [7:0] CMD_FAULT_ACTION    = 8'h5A;
  localparam logic [7:0] CMD_CLEAR_FAULTS    = 8'h03;

  // ---------------------------------------------------------------
  // Reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [15:0] THRESHOLD_RESET = 16'hCB40;
  localparam logic [7:0]  ACTION_RESET    = 8'h80;
  localparam logic [1:0]  MODE_RETRY      = 2'h2;
  localparam int          MODE_HI         = 7;
  localparam int          MODE_LO         = 6;
  localparam int          RETRY_HI        = 5;
  localparam int          RETRY_LO        = 3;
  localparam int          DELAY_HI        = 2;
  localparam int          DELAY_LO        = 0;
  localparam int          EXP_HI          = 15;
  localparam int          EXP_LO          = 11;
  localparam int          MANT_HI         = 10;

  // Voltages in millivolts; limits 0 V to 16 V
  localparam int          MV_MAX          = 16000;
  localparam int          MV_PER_V        = 1000;

  // Status bit positions
  localparam int          SW_NONE_ABOVE   = 0;
  localparam int          SW_INPUT        = 13;
  localparam int          SI_UV_FAULT     = 4;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int          CLK_HZ          = 10_000_000;
  localparam int          RETRY_UNIT_MS   = 35;
  localparam int          RETRY_UNIT_CYC  = RETRY_UNIT_MS * (CLK_HZ / 1000);

  // ---------------------------------------------------------------
  // Fault handling states, Gray along the usual path
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    IUV_RUN     = 2'h0,
    IUV_OFF     = 2'h1,
    IUV_WAIT    = 2'h3,
    IUV_RESTART = 2'h2
  } iuv_state_t;
endpackage

/* File: core/iuv_lin11.sv */
// Linear-11 to signed millivolt converter
module iuv_lin11 (
  input  wire logic [15:0] code,      // Linear-11 word
  output logic signed [31:0] mv       // Value in millivolts
);
  logic signed [4:0]  exp_s;
  logic signed [10:0] mant_s;
  logic signed [63:0] wide;

  // Wide product so large exponents saturate instead of wrapping into range
  always_comb begin
    exp_s  = code[iuv_pkg::EXP_HI:iuv_pkg::EXP_LO];
    mant_s = code[iuv_pkg::MANT_HI:0];
    wide   = 64'(mant_s) * 64'(iuv_pkg::MV_PER_V);
    if (exp_s < 0) begin
      wide = wide >>> (-exp_s);
    end else begin
      wide = wide <<< exp_s;
    end
    if (wide > 64'sh0000_0000_7FFF_FFFF) begin
      mv = 32'sh7FFF_FFFF;
    end else if (wide < 64'shFFFF_FFFF_8000_0000) begin
      mv = 32'sh8000_0000;
    end else begin
      mv = wide[31:0];
    end
  end
endmodule

/* File: verif/iuv_host.sv */
// Host model: command writes and reads toward the handler
module iuv_host (
  input  wire logic        clk_sys,  // System clock
  output logic             cmd_wr,   // Write strobe
  output logic      [7:0]  cmd_code, // Command code
  output logic      [15:0] cmd_data, // Write data
  output logic      [7:0]  rd_code,  // Read code
  input  wire logic [15:0] rd_data   // Read data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_wr = 1'b0;
    cmd_code = 8'h00;
    cmd_data = 16'h0000;
    rd_code = 8'h00;
  end
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    cmd_wr = 1'b1;
    cmd_code = c;
    cmd_data = d;
    @(posedge clk_sys);
    #1;
    cmd_wr = 1'b0;
    cmd_data = ~d; // Released data must not linger
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    @(posedge clk_sys);
    #1;
    rd_code = c;
    repeat (2) @(posedge clk_sys);
    #1;
    d = rd_data;
  endtask
endmodule

/* File: verif/iuv_fault_bench.sv */
// Bench for the input undervoltage handler
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; $display("MISMATCH %0t %h", $time, a); end end
module iuv_fault_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int UNIT = 20;
  logic        clk_sys, resetn, cmd_wr, meas_valid, on, alert_n, en;
  logic [7:0]  cmd_code, rd_code, si;
  logic [15:0] cmd_data, rd_data, meas_vin, warn, sw, d, q;
  int          num_errors = 0;
  int          compares = 0;
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  iuv_host host_inst (.clk_sys(clk_sys), .cmd_wr(cmd_wr), .cmd_code(cmd_code), .cmd_data(cmd_data),
    .rd_code(rd_code), .rd_data(rd_data));
  iuv_fault #(.RETRY_UNIT(UNIT)) iuv_fault_inst (.clk_sys(clk_sys), .resetn(resetn), .cmd_wr(cmd_wr),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .rd_code(rd_code), .rd_data(rd_data), .meas_valid(meas_valid),
    .meas_vin(meas_vin), .warn_threshold(warn), .output_enable_in(en), .output_on(on),
    .host_alert_line_n(alert_n), .status_word(sw), .status_input(si));
  task automatic meas(input logic [15:0] v);
    @(posedge clk_sys);
    #1;
    meas_vin = v;
    meas_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    meas_valid = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  function automatic logic [15:0] code_of(input int r);
    return {5'h19, 1'b0, r[9:0]}; // Exponent -7, positive mantissa, below 8 V
  endfunction
  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #5ms;
    num_errors++;
    end_sim();
  end
  initial begin
    resetn = 1'b0;
    en = 1'b1;
    meas_valid = 1'b0;
    meas_vin = 16'hD200;
    warn = 16'hCB80; // Warning kept above fault threshold
    void'($urandom(93));
    repeat (4) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    host_inst.rd(iuv_pkg::CMD_FAULT_THRESHOLD, d);
    `CHK(d, iuv_pkg::THRESHOLD_RESET)
    host_inst.rd(iuv_pkg::CMD_FAULT_ACTION, d);
    `CHK(d[7:0], iuv_pkg::ACTION_RESET)
    for (int i = 0; i < 4; i++) begin
      d = code_of($urandom);
      host_inst.wr(iuv_pkg::CMD_FAULT_THRESHOLD, d);
      host_inst.wr(iuv_pkg::CMD_FAULT_THRESHOLD, i[0] ? 16'h0A00 : 16'hCF00);
      host_inst.rd(iuv_pkg::CMD_FAULT_THRESHOLD, q);
      `CHK(q, d)
    end
    host_inst.wr(iuv_pkg::CMD_FAULT_THRESHOLD, iuv_pkg::THRESHOLD_RESET);
    meas(16'hCB00);
    `CHK({sw[13], sw[0], si[4], alert_n, on}, 5'b11100)
    meas(16'hD200);
    wait_cyc(4 * UNIT);
    `CHK({si[4], on}, 2'b10)
    host_inst.wr(iuv_pkg::CMD_CLEAR_FAULTS, 16'h0000);
    wait_cyc(3);
    `CHK({si[4], sw[13], alert_n, on}, 4'b0011)
    en = 1'b0;
    wait_cyc(4);
    `CHK(on, 1'b0)
    en = 1'b1;
    wait_cyc(4);
    `CHK(on, 1'b1)
    // Delay code 1: two units from the fault edge to the restart
    host_inst.wr(iuv_pkg::CMD_FAULT_ACTION, 16'h0089);
    meas(16'hCB00);
    meas(16'hD200);
    wait_cyc(2 * UNIT - 9);
    `CHK(on, 1'b0)
    wait_cyc(2);
    `CHK(on, 1'b1)
    meas(16'hCB00);
    meas(16'hCB60);
    wait_cyc(4 * UNIT);
    `CHK(on, 1'b0)
    meas(16'hD200);
    `CHK(on, 1'b1)
    // Unused response code: stays off until cleared
    host_inst.wr(iuv_pkg::CMD_FAULT_ACTION, 16'h0049);
    meas(16'hCB00);
    meas(16'hD200);
    wait_cyc(4 * UNIT);
    `CHK(on, 1'b0)
    host_inst.wr(iuv_pkg::CMD_CLEAR_FAULTS, 16'h0000);
    wait_cyc(3);
    `CHK({si[4], on}, 2'b01)
    end_sim();
  end
endmodule
